// ### inc/adcs_pkg.sv
// Shared constants and carrier types for the converter status block.
// Assumes a single 250 MHz clock and an APB master on the register side.
package adcs_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int ADCS_AW   = 8;   // APB byte address width
    localparam int ADCS_DW   = 32;  // APB data width
    localparam int ADCS_NCH  = 8;   // Converter channels
    localparam int ADCS_CHW  = 3;   // Channel number width
    localparam int ADCS_RW   = 10;  // Result width
    localparam int ADCS_CW   = 16;  // DMA receive counter width
    localparam int ADCS_SRW  = 20;  // Used status and mask bits

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [ADCS_AW-1:0] ADCS_OFF_CHSR = 8'h18;
    localparam logic [ADCS_AW-1:0] ADCS_OFF_SR   = 8'h1C;
    localparam logic [ADCS_AW-1:0] ADCS_OFF_LAST = 8'h20;
    localparam logic [ADCS_AW-1:0] ADCS_OFF_IER  = 8'h24;
    localparam logic [ADCS_AW-1:0] ADCS_OFF_IDR  = 8'h28;
    localparam logic [ADCS_AW-1:0] ADCS_OFF_IMR  = 8'h2C;
    localparam logic [ADCS_AW-1:0] ADCS_OFF_CDR0 = 8'h30;
    localparam logic [ADCS_AW-1:0] ADCS_OFF_CDR7 = 8'h4C;

    // ****************************************************************
    // Status and mask field positions
    // ****************************************************************
    localparam int ADCS_BIT_EOC    = 0;
    localparam int ADCS_BIT_OVR    = 8;
    localparam int ADCS_BIT_READY  = 16;
    localparam int ADCS_BIT_GOVR   = 17;
    localparam int ADCS_BIT_RXDONE = 18;
    localparam int ADCS_BIT_RXFULL = 19;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [ADCS_SRW-1:0] ADCS_RST_MASK   = 20'h00000;
    localparam logic                ADCS_RST_RXDONE = 1'b1;
    localparam logic [ADCS_RW-1:0]  ADCS_RST_DATA   = 10'h0;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic               psel;
        logic               penable;
        logic               pwrite;
        logic [ADCS_AW-1:0] paddr;
        logic [ADCS_DW-1:0] pwdata;
    } adcs_apb_req_type;

    typedef struct packed {
        logic [ADCS_DW-1:0] prdata;
        logic               pready;
        logic               pslverr;
    } adcs_apb_rsp_type;

    typedef struct packed {
        logic                done;
        logic [ADCS_CHW-1:0] chan;
        logic [ADCS_RW-1:0]  data;
    } adcs_conv_type;

    typedef struct packed {
        logic [ADCS_CW-1:0] rcr;
        logic [ADCS_CW-1:0] rncr;
        logic               wr;
    } adcs_dma_type;

    typedef struct packed {
        logic [ADCS_RW-1:0] result;
        logic               eoc;
        logic               ovr;
    } adcs_chan_state_type;

    typedef struct packed {
        adcs_apb_rsp_type    rsp;
        logic                irq;
        logic [ADCS_SRW-1:0] mask;
        logic                ready;
        logic                govr;
        logic                rxdone;
        logic                rcr_nz;
        logic [ADCS_RW-1:0]  last;
    } adcs_state_type;

endpackage

// ### hdl/adcs_chan.sv
// One converter channel: result slot, end-of-conversion and overrun.
// Assumes load is already qualified by the channel enable.
`timescale 1ns/1ps
module adcs_chan
    import adcs_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Events
    input  wire logic               load,
    input  wire logic [ADCS_RW-1:0] data,
    input  wire logic               rd_result,
    input  wire logic               rd_status,
    // State
    output logic [ADCS_RW-1:0]      result,
    output logic                    eoc,
    output logic                    ovr
);

    adcs_chan_state_type st_reg;
    adcs_chan_state_type st_next;

    // Next state; a set always beats a clear in the same cycle
    always_comb begin
        st_next = st_reg;
        if (rd_result) begin
            st_next.eoc = 1'b0;
        end
        if (rd_status) begin
            st_next.ovr = 1'b0;
        end
        if (load) begin
            st_next.result = data;
            st_next.eoc    = 1'b1;
            // Unread result overwritten; a read in this cycle saved it
            if (st_reg.eoc && !rd_result) begin
                st_next.ovr = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '{result: ADCS_RST_DATA, eoc: 1'b0, ovr: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign result = st_reg.result;
    assign eoc    = st_reg.eoc;
    assign ovr    = st_reg.ovr;

endmodule

// ### hdl/adcs_regs.sv
// Status, interrupt mask and result registers of an 8-channel converter.
// Assumes channel enables, conversion events and DMA counters come from
// logic on the same clock; software reaches the registers over APB.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps

// What this block does
// - Channel status reads one bit per channel, 1 when enabled.
// - End-of-conversion bit reads 1 only if enabled and conversion done.
// - Channel overrun bits set on overrun, cleared by status read.
// - Data-ready sets on any result, cleared by reading last result.
// - General overrun sets on any general overrun, cleared by status read.
// - Receive-done sets when counter reaches zero, cleared by counter write.
// - Buffers-full reads 1 exactly when both receive counters are zero.
// - Last result captures every conversion and holds until the next.
// - Channel result loads only when enabled, holds until next conversion.
// - Writing 1 to enable-set register sets that mask bit.
// - Writing 1 to enable-clear register clears that mask bit.
// - Mask view reads enabled sources, same layout as status.
module adcs_regs
    import adcs_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // APB slave
    input  wire adcs_apb_req_type    apb_req,
    output adcs_apb_rsp_type         apb_rsp,
    // Converter side
    input  wire adcs_conv_type       conv,
    input  wire logic [ADCS_NCH-1:0] chan_en,
    // DMA receive counters
    input  wire adcs_dma_type        dma,
    // Interrupt
    output logic                     irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    adcs_state_type      st_reg;
    adcs_state_type      st_next;
    logic                acc_wait;
    logic                acc_done;
    logic                rd_done;
    logic                rd_sr;
    logic                rd_last;
    logic                wr_ier;
    logic                wr_idr;
    logic [ADCS_AW-1:0]  cdr_off;
    logic                cdr_hit;
    logic [ADCS_CHW-1:0] cdr_idx;
    logic                rx_full;
    logic [ADCS_SRW-1:0] sr_view;
    logic [ADCS_NCH-1:0] ch_load;
    logic [ADCS_NCH-1:0] ch_rd;
    logic [ADCS_NCH-1:0] ch_eoc;
    logic [ADCS_NCH-1:0] ch_ovr;
    logic [ADCS_RW-1:0]  ch_result [ADCS_NCH];

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // Access phase still waiting, and the edge that completes it
    assign acc_wait = apb_req.psel && apb_req.penable && !st_reg.rsp.pready;
    assign acc_done = apb_req.psel && apb_req.penable && st_reg.rsp.pready;
    assign rd_done  = acc_done && !apb_req.pwrite;
    // Read side effects land only on the completing edge
    assign rd_sr    = rd_done && (apb_req.paddr == ADCS_OFF_SR);
    assign rd_last  = rd_done && (apb_req.paddr == ADCS_OFF_LAST);
    assign wr_ier   = acc_done && apb_req.pwrite
                      && (apb_req.paddr == ADCS_OFF_IER);
    assign wr_idr   = acc_done && apb_req.pwrite
                      && (apb_req.paddr == ADCS_OFF_IDR);

    // Result window decode; channel 0 sits at the lowest word
    assign cdr_off = apb_req.paddr - ADCS_OFF_CDR0;
    assign cdr_hit = (apb_req.paddr >= ADCS_OFF_CDR0)
                     && (apb_req.paddr <= ADCS_OFF_CDR7)
                     && (apb_req.paddr[1:0] == 2'h0);
    assign cdr_idx = cdr_off[4:2];

    // ****************************************************************
    // Status view
    // ****************************************************************
    // both counters zero
    assign rx_full = (dma.rcr == '0) && (dma.rncr == '0);

    assign sr_view = {rx_full, st_reg.rxdone, st_reg.govr, st_reg.ready,
                      ch_ovr, ch_eoc & chan_en};

    // ****************************************************************
    // Channels
    // ****************************************************************
    // One slot per channel; load and read strobes decoded per entry
    for (genvar i = 0; i < ADCS_NCH; i++) begin : g_chan
        assign ch_load[i] = conv.done && (conv.chan == ADCS_CHW'(i))
                            && chan_en[i];
        assign ch_rd[i]   = rd_done && cdr_hit
                            && (cdr_idx == ADCS_CHW'(i));
        adcs_chan u_chan (
            .clk       (clk),
            .rst       (rst),
            .load      (ch_load[i]),
            .data      (conv.data),
            .rd_result (ch_rd[i]),
            .rd_status (rd_sr),
            .result    (ch_result[i]),
            .eoc       (ch_eoc[i]),
            .ovr       (ch_ovr[i])
        );
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Answer one cycle into the access phase, so prdata is registered
    always_comb begin
        st_next = st_reg;
        st_next.rsp.pready  = acc_wait;
        st_next.rsp.prdata  = '0;
        st_next.rsp.pslverr = 1'b0;
        if (acc_wait && !apb_req.pwrite) begin
            case (apb_req.paddr)
                ADCS_OFF_CHSR: begin
                    st_next.rsp.prdata = {24'h000000, chan_en};
                end
                ADCS_OFF_SR: begin
                    st_next.rsp.prdata = {12'h000, sr_view};
                end
                ADCS_OFF_LAST: begin
                    st_next.rsp.prdata = {22'h0, st_reg.last};
                end
                ADCS_OFF_IMR: begin
                    st_next.rsp.prdata = {12'h000, st_reg.mask};
                end
                ADCS_OFF_IER, ADCS_OFF_IDR: begin
                    st_next.rsp.prdata = '0;
                end
                default: begin
                    if (cdr_hit) begin
                        st_next.rsp.prdata =
                            {22'h0, ch_result[cdr_idx]};
                    end else begin
                        st_next.rsp.pslverr = 1'b1;
                    end
                end
            endcase
        end else if (acc_wait) begin
            // Writes to read-only words are dropped silently
            case (apb_req.paddr)
                ADCS_OFF_CHSR, ADCS_OFF_SR, ADCS_OFF_LAST,
                ADCS_OFF_IER, ADCS_OFF_IDR, ADCS_OFF_IMR: begin
                    st_next.rsp.pslverr = 1'b0;
                end
                default: begin
                    st_next.rsp.pslverr = !cdr_hit;
                end
            endcase
        end

        if (wr_ier) begin
            st_next.mask = st_next.mask | apb_req.pwdata[ADCS_SRW-1:0];
        end
        if (wr_idr) begin
            st_next.mask = st_next.mask & ~apb_req.pwdata[ADCS_SRW-1:0];
        end

        if (rd_last) begin
            st_next.ready = 1'b0;
        end
        if (conv.done) begin
            st_next.ready = 1'b1;
        end

        if (rd_sr) begin
            st_next.govr = 1'b0;
        end
        if (conv.done && st_reg.ready && !rd_last) begin
            st_next.govr = 1'b1;
        end

        if (conv.done) begin
            st_next.last = conv.data;
        end

        // counter write clears, reaching zero sets
        st_next.rcr_nz = (dma.rcr != '0);
        if (dma.wr) begin
            st_next.rxdone = 1'b0;
        end
        if (st_reg.rcr_nz && (dma.rcr == '0)) begin
            st_next.rxdone = 1'b1;
        end

        st_next.irq = |(sr_view & st_reg.mask);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg.rsp    <= '{prdata: '0, pready: 1'b0, pslverr: 1'b0};
            st_reg.irq    <= 1'b0;
            st_reg.mask   <= ADCS_RST_MASK;
            st_reg.ready  <= 1'b0;
            st_reg.govr   <= 1'b0;
            st_reg.rxdone <= ADCS_RST_RXDONE;
            st_reg.rcr_nz <= 1'b0;
            st_reg.last   <= ADCS_RST_DATA;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    assign apb_rsp = st_reg.rsp;
    assign irq     = st_reg.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_chsr_read;
        acc_wait && !apb_req.pwrite && (apb_req.paddr == ADCS_OFF_CHSR)
        |=> apb_rsp.pready && (apb_rsp.prdata == {24'h0, $past(chan_en)});
    endproperty
    a_chsr_read: assert property (p_chsr_read)
        else $error("channel status read wrong");

    property p_eoc_set;
        conv.done && chan_en[conv.chan] && $stable(chan_en)
        |=> ch_eoc[$past(conv.chan)];
    endproperty
    a_eoc_set: assert property (p_eoc_set)
        else $error("end of conversion not set");

    property p_ovr_hold;
        !rd_sr |=> ((ch_ovr & $past(ch_ovr)) == $past(ch_ovr));
    endproperty
    a_ovr_hold: assert property (p_ovr_hold)
        else $error("channel overrun lost without status read");

    property p_ready_cycle;
        rd_last && !conv.done |=> !st_reg.ready;
    endproperty
    a_ready_cycle: assert property (p_ready_cycle)
        else $error("data ready not cleared by last read");

    property p_govr_set;
        conv.done && st_reg.ready && !rd_last |=> st_reg.govr [*1] ##0
        (rd_sr || st_reg.govr);
    endproperty
    a_govr_set: assert property (p_govr_set)
        else $error("general overrun missed");

    property p_govr_clear;
        rd_sr && !conv.done |=> !st_reg.govr;
    endproperty
    a_govr_clear: assert property (p_govr_clear)
        else $error("general overrun not cleared by status read");

    property p_rxdone;
        dma.wr && !(st_reg.rcr_nz && dma.rcr == '0) |=> !st_reg.rxdone;
    endproperty
    a_rxdone: assert property (p_rxdone)
        else $error("receive done not cleared by counter write");

    property p_last;
        conv.done |=> (st_reg.last == $past(conv.data)) && st_reg.ready;
    endproperty
    a_last: assert property (p_last)
        else $error("last result not captured");

    property p_ier;
        wr_ier && !wr_idr
        |=> st_reg.mask == ($past(st_reg.mask)
                            | $past(apb_req.pwdata[ADCS_SRW-1:0]));
    endproperty
    a_ier: assert property (p_ier)
        else $error("mask set write wrong");

    property p_idr;
        wr_idr
        |=> (st_reg.mask & $past(apb_req.pwdata[ADCS_SRW-1:0])) == '0;
    endproperty
    a_idr: assert property (p_idr)
        else $error("mask clear write wrong");

    property p_irq;
        |(sr_view & st_reg.mask) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    property p_ovr_set;
        conv.done && chan_en[conv.chan] && ch_eoc[conv.chan]
        && !ch_rd[conv.chan]
        |=> ch_ovr[$past(conv.chan)];
    endproperty
    a_ovr_set: assert property (p_ovr_set)
        else $error("channel overrun not set");

    property p_result_gate;
        conv.done && !chan_en[conv.chan]
        |=> ch_result[$past(conv.chan)] == $past(ch_result[conv.chan]);
    endproperty
    a_result_gate: assert property (p_result_gate)
        else $error("disabled channel result changed");

    property p_mask_read;
        acc_wait && !apb_req.pwrite && (apb_req.paddr == ADCS_OFF_IMR)
        |=> apb_rsp.prdata == {12'h000, $past(st_reg.mask)};
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask view read wrong");

    property p_rx_full;
        acc_wait && !apb_req.pwrite && (apb_req.paddr == ADCS_OFF_SR)
        |=> apb_rsp.prdata[ADCS_BIT_RXFULL]
            == $past((dma.rcr == '0) && (dma.rncr == '0));
    endproperty
    a_rx_full: assert property (p_rx_full)
        else $error("buffers full flag wrong");

    c_govr: cover property (conv.done && st_reg.ready);
    c_ovr:  cover property (|ch_ovr ##1 rd_sr);
    c_irq:  cover property ($rose(irq));

endmodule

// ### bench/adcs_far_model.sv
// Far side of the status block: conversion sequencer, channel enables
// and the DMA receive counters. Assumes one bench process calls its
// tasks, each aligned to the rising edge of clk.
`timescale 1ns/1ps
module adcs_far_model
    import adcs_pkg::*;
(
    // Clock
    input  wire logic           clk,
    // Converter side
    output adcs_conv_type       conv,
    output logic [ADCS_NCH-1:0] chan_en,
    // DMA receive counters
    output adcs_dma_type        dma
);
    // Idle values at time zero so no block input floats
    initial begin
        conv    = '0;
        chan_en = '0;
        dma     = '0;
    end

    task automatic set_enables(input logic [ADCS_NCH-1:0] en);
        @(posedge clk);
        chan_en <= en;
    endtask

    // One-cycle completion pulse; stale data is inverted, not held
    task automatic convert(input logic [ADCS_CHW-1:0] ch,
                           input logic [ADCS_RW-1:0]  d);
        @(posedge clk);
        conv <= '{done: 1'b1, chan: ch, data: d};
        @(posedge clk);
        conv.done <= 1'b0;
        conv.chan <= ~ch;
        conv.data <= ~d;
    endtask

    // New counter levels, with an optional one-cycle software write
    task automatic counters(input logic [ADCS_CW-1:0] rcr,
                            input logic [ADCS_CW-1:0] rncr,
                            input logic               wr);
        @(posedge clk);
        dma <= '{rcr: rcr, rncr: rncr, wr: wr};
        if (wr) begin
            @(posedge clk);
            dma.wr <= 1'b0;
        end
    endtask
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the converter status and interrupt registers.
// Assumes the far side model drives conversions, enables and counters,
// and that the block answers APB with the wait state of its note.
`timescale 1ns/1ps
module tb_top
    import adcs_pkg::*;
;
    logic                clk;
    logic                rst;
    adcs_apb_req_type    apb_req;
    adcs_apb_rsp_type    apb_rsp;
    adcs_conv_type       conv;
    logic [ADCS_NCH-1:0] chan_en;
    adcs_dma_type        dma;
    logic                irq;
    int                  n_errors;
    int                  samples_checked;

    adcs_regs u_adcs_regs (
        .clk     (clk),
        .rst     (rst),
        .apb_req (apb_req),
        .apb_rsp (apb_rsp),
        .conv    (conv),
        .chan_en (chan_en),
        .dma     (dma),
        .irq     (irq)
    );

    adcs_far_model u_adcs_far_model (
        .clk     (clk),
        .conv    (conv),
        .chan_en (chan_en),
        .dma     (dma)
    );

    // 250 MHz clock
    initial clk = 1'b0;
    always #2 clk = ~clk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [ADCS_DW-1:0] got,
                              input logic [ADCS_DW-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input  logic               wr,
                       input  logic [ADCS_AW-1:0] a,
                       input  logic [ADCS_DW-1:0] wd,
                       output logic [ADCS_DW-1:0] rd,
                       output logic               err);
        int i;
        @(posedge clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr,
                     paddr: a, pwdata: wd};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (apb_rsp.pready === 1'b1) break;
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        if (i == 50) begin
            n_errors++;
            $display("MISMATCH %0t no pready", $time);
            final_report();
        end
    endtask

    task automatic rd_chk(input logic [ADCS_AW-1:0] a,
                          input logic [ADCS_DW-1:0] exp);
        logic [ADCS_DW-1:0] rd;
        logic               err;
        apb(1'b0, a, '0, rd, err);
        check_word(rd, exp);
        check_bit(err, 1'b0);
    endtask

    task automatic wr(input logic [ADCS_AW-1:0] a,
                      input logic [ADCS_DW-1:0] d);
        logic [ADCS_DW-1:0] rd;
        logic               err;
        apb(1'b1, a, d, rd, err);
    endtask

    // Let registered outputs land before they are looked at
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rd_chk(ADCS_OFF_SR, 32'h000C0000);
        rd_chk(ADCS_OFF_IMR, 32'h00000000);
        rd_chk(ADCS_OFF_LAST, 32'h00000000);
        rd_chk(ADCS_OFF_CDR7, 32'h00000000);
        check_bit(irq, 1'b0);
        $display("t_reset done");
    endtask

    task automatic t_chsr();
        logic [ADCS_NCH-1:0] pat [3] = '{8'h00, 8'hA5, 8'h5A};
        foreach (pat[i]) begin
            u_adcs_far_model.set_enables(pat[i]);
            rd_chk(ADCS_OFF_CHSR, {24'h000000, pat[i]});
        end
        $display("t_chsr done");
    endtask

    task automatic t_conv();
        u_adcs_far_model.set_enables(8'h04);
        u_adcs_far_model.counters(16'h0003, 16'h0000, 1'b1);
        u_adcs_far_model.convert(3'h2, 10'h3FF);
        rd_chk(ADCS_OFF_SR, 32'h00010004);
        // Disabled channel still feeds the last result
        u_adcs_far_model.convert(3'h5, 10'h155);
        rd_chk(ADCS_OFF_SR, 32'h00030004);
        rd_chk(ADCS_OFF_SR, 32'h00010004);
        rd_chk(ADCS_OFF_LAST, 32'h00000155);
        rd_chk(ADCS_OFF_SR, 32'h00000004);
        rd_chk(ADCS_OFF_CDR0 + 8'h14, 32'h0);
        rd_chk(ADCS_OFF_CDR0 + 8'h08, 32'h3FF);
        rd_chk(ADCS_OFF_SR, 32'h00000000);
        // Second result on a channel whose flag is still up
        u_adcs_far_model.convert(3'h2, 10'h0AA);
        u_adcs_far_model.convert(3'h2, 10'h0BB);
        rd_chk(ADCS_OFF_SR, 32'h00030404);
        rd_chk(ADCS_OFF_SR, 32'h00010004);
        rd_chk(ADCS_OFF_LAST, 32'h000000BB);
        // Completed slot hidden once its channel is off
        u_adcs_far_model.set_enables(8'h00);
        rd_chk(ADCS_OFF_SR, 32'h00000000);
        u_adcs_far_model.set_enables(8'h04);
        rd_chk(ADCS_OFF_CDR0 + 8'h08, 32'h0BB);
        $display("t_conv done");
    endtask

    task automatic t_dma();
        u_adcs_far_model.counters(16'h0002, 16'h0001, 1'b1);
        rd_chk(ADCS_OFF_SR, 32'h00000000);
        u_adcs_far_model.counters(16'h0000, 16'h0001, 1'b0);
        rd_chk(ADCS_OFF_SR, 32'h00040000);
        u_adcs_far_model.counters(16'h0000, 16'h0000, 1'b0);
        rd_chk(ADCS_OFF_SR, 32'h000C0000);
        u_adcs_far_model.counters(16'h0000, 16'h0000, 1'b1);
        rd_chk(ADCS_OFF_SR, 32'h00080000);
        u_adcs_far_model.counters(16'h0005, 16'h0000, 1'b0);
        rd_chk(ADCS_OFF_SR, 32'h00000000);
        $display("t_dma done");
    endtask

    task automatic t_irq();
        logic [ADCS_DW-1:0] rd;
        logic               err;
        wr(ADCS_OFF_IER, 32'hFFFFFFFF);
        rd_chk(ADCS_OFF_IMR, 32'h000FFFFF);
        wr(ADCS_OFF_IDR, 32'h000FFFFF);
        rd_chk(ADCS_OFF_IMR, 32'h00000000);
        wr(ADCS_OFF_IER, 32'h00010004);
        wr(ADCS_OFF_IER, 32'h00000000);
        rd_chk(ADCS_OFF_IMR, 32'h00010004);
        wr(ADCS_OFF_IDR, 32'h00000004);
        wr(ADCS_OFF_IDR, 32'h00000000);
        rd_chk(ADCS_OFF_IMR, 32'h00010000);
        check_bit(irq, 1'b0);
        u_adcs_far_model.convert(3'h3, 10'h001);
        settle(2);
        check_bit(irq, 1'b1);
        wr(ADCS_OFF_IDR, 32'h00010000);
        settle(2);
        check_bit(irq, 1'b0);
        wr(ADCS_OFF_IER, 32'h00010000);
        settle(2);
        check_bit(irq, 1'b1);
        rd_chk(ADCS_OFF_LAST, 32'h00000001);
        settle(2);
        check_bit(irq, 1'b0);
        // Refused and read-only places
        apb(1'b0, 8'h50, '0, rd, err);
        check_bit(err, 1'b1);
        apb(1'b1, 8'h50, 32'hFFFFFFFF, rd, err);
        check_bit(err, 1'b1);
        apb(1'b1, ADCS_OFF_CDR0, 32'hFFFFFFFF, rd, err);
        check_bit(err, 1'b0);
        rd_chk(ADCS_OFF_CDR0, 32'h00000000);
        rd_chk(ADCS_OFF_IER, 32'h00000000);
        wr(ADCS_OFF_IMR, 32'hFFFFFFFF);
        rd_chk(ADCS_OFF_IMR, 32'h00010000);
        $display("t_irq done");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst = 1'b1;
        apb_req = '0;
        n_errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_chsr();
        t_conv();
        t_dma();
        t_irq();
        final_report();
    end
endmodule
